// file: design/crtt_pkg.sv
// Constants, register map and carrier types for the CRT raster timer
package crtt_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int CHAR_PIXELS  = 8;
  localparam int CHAR_DIV_W   = 3;
  localparam int HCNT_W       = 9;
  localparam int VCNT_W       = 10;
  localparam int EV_W         = 10;
  localparam int HSE_CMP_W    = 5;
  localparam int HBE_CMP_W    = 6;
  localparam int VSE_CMP_W    = 4;
  localparam int VBE_CMP_W    = 8;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int BYTE_W       = 8;
  localparam int EXT_W        = 12;
  localparam logic [CHAR_DIV_W-1:0] CHAR_LAST = 3'h7;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_HTOTAL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_HDISP   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_HBSTART = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_HBEND   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_HSSTART = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_HSEND   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_VTOTAL  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_VSSTART = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_VSEND   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_VDISP   = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_VBSTART = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_VBEND   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_EXT     = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_MISC    = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_VPCTRL  = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_FEAT    = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_GFXEXT  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CFGIRQ  = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_POS     = 8'h48;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [BYTE_W-1:0] RST_HTOTAL  = 8'h5F;
  localparam logic [BYTE_W-1:0] RST_HDISP   = 8'h50;
  localparam logic [BYTE_W-1:0] RST_HBSTART = 8'h50;
  localparam logic [BYTE_W-1:0] RST_HBEND   = 8'h5F;
  localparam logic [BYTE_W-1:0] RST_HSSTART = 8'h54;
  localparam logic [BYTE_W-1:0] RST_HSEND   = 8'h5C;
  localparam logic [BYTE_W-1:0] RST_VTOTAL  = 8'h0C;
  localparam logic [BYTE_W-1:0] RST_VSSTART = 8'hEA;
  localparam logic [BYTE_W-1:0] RST_VDISP   = 8'hE0;
  localparam logic [BYTE_W-1:0] RST_VBSTART = 8'hE0;
  localparam logic [BYTE_W-1:0] RST_VBEND   = 8'h0C;
  localparam logic [3:0]        RST_VSEND   = 4'hC;
  localparam logic [BYTE_W-1:0] IRQ_NONE    = 8'h00;
  localparam logic [BYTE_W-1:0] IRQ_PIN_DEF = 8'h01;
  localparam logic [EXT_W-1:0]  RST_EXT     = 12'h2AA;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [EV_W-1:0] total;
    logic [EV_W-1:0] disp_end;
    logic [EV_W-1:0] blank_start;
    logic [EV_W-1:0] blank_end;
    logic [EV_W-1:0] sync_start;
    logic [EV_W-1:0] sync_end;
  } crtt_axis_cfg_t;

  typedef struct packed {
    logic [1:0] vss_hi;
    logic [1:0] vbs_hi;
    logic [1:0] vdisp_hi;
    logic [1:0] vtotal_hi;
    logic       hss_hi;
    logic       hbs_hi;
    logic       hdisp_hi;
    logic       htotal_hi;
  } crtt_ext_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic       frame_irq_clear;
    logic       frame_irq_enable;
    logic [3:0] sync_end;
  } crtt_vse_t;

  typedef struct packed {
    logic       vsync_neg;
    logic       hsync_neg;
    logic [5:0] rsvd;
  } crtt_misc_t;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       irq_source_select;
    logic [2:0] rsvd_mid;
    logic       vport_irq_enable_clear;
    logic       rsvd_lo;
  } crtt_vpctrl_t;

  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic       vport_irq_pending;
    logic       rsvd_mid;
    logic       irq_pin_enable;
    logic [1:0] rsvd_lo;
  } crtt_gfxext_t;

endpackage

// file: design/crtt_flag.sv
// Sticky pending flag in which a set beats a clear in the same cycle
module crtt_flag
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic set_i,
  input  wire logic clr_i,
  // State
  output logic      flag_o
);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clr_i)
      flag_o <= 1'b0;
  end

endmodule

// file: design/crtt_axis.sv
// One raster axis: up counter with display, blank and sync periods
module crtt_axis
#(
  parameter int W   = 9,
  parameter int SEW = 5,
  parameter int BEW = 6
)
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // Advance and programmed events
  input  wire logic                    adv_i,
  input  wire crtt_pkg::crtt_axis_cfg_t cfg_i,
  // Raster state
  output logic [W-1:0]                 count_o,
  output logic                         active_o,
  output logic                         blank_o,
  output logic                         sync_o,
  output logic                         wrap_o,
  output logic                         sync_hit_o
);

  logic [W-1:0] count_nxt;

  always_comb
  begin
    wrap_o    = adv_i && (count_o == cfg_i.total[W-1:0]);
    count_nxt = count_o;
    if (wrap_o)
      count_nxt = '0;
    else if (adv_i)
      count_nxt = W'(count_o + 1'b1);
    sync_hit_o = adv_i && (count_nxt == cfg_i.sync_start[W-1:0]);
    active_o   = count_o < cfg_i.disp_end[W-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      count_o <= '0;
    else
      count_o <= count_nxt;
  end

  // Blank period opens at its start, closes on a low-bit match
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      blank_o <= 1'b0;
    else if (adv_i && count_nxt == cfg_i.blank_start[W-1:0])
      blank_o <= 1'b1;
    else if (adv_i && count_nxt[BEW-1:0] == cfg_i.blank_end[BEW-1:0])
      blank_o <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sync_o <= 1'b0;
    else if (sync_hit_o)
      sync_o <= 1'b1;
    else if (adv_i && count_nxt[SEW-1:0] == cfg_i.sync_end[SEW-1:0])
      sync_o <= 1'b0;
  end

endmodule

// file: design/crtt_top.sv
// CRT raster timing generator with frame and video-port interrupt path
//
// How it works
// - horizontal count advances every eight pixels
// - vertical count runs in scanlines
// - counters run zero to total, then wrap
// - horizontal zero is first active pixel
// - vertical zero is top displayed scanline
// - six event compares shape each axis
// - wide values use main byte plus extension
// - sync and blank end compare low bits
// - sync polarity comes from misc register
// - strap high: pin idle, no line claimed
// - strap low: interrupt line advertised
// - pin enable resets to zero
// - pin low needs strap, enable, request
// - source select picks frame or port edge
// - separate pending bits per source
// - separate enable bits per source
// - frame clear bit; port enable clears
//
// Added by the designer: the register addresses and register access over APB.
module crtt_top
#(
  parameter logic [7:0] IRQ_PIN_CODE = crtt_pkg::IRQ_PIN_DEF
)
(
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RESETN_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Strap and video port
  input  wire logic        IRQ_DISABLE_STRAP_I,
  input  wire logic        VPORT_REF_I,
  // Monitor timing
  output logic             HSYNC_O,
  output logic             VSYNC_O,
  output logic             BLANK_O,
  output logic             DISP_EN_O,
  // Interrupt pin
  output logic             IRQ_OUT_N_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [crtt_pkg::BYTE_W-1:0]     horiz_total_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     horiz_display_end_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     horiz_blank_start_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     horiz_blank_end_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     horiz_sync_start_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     horiz_sync_end_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     vert_total_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     vert_sync_start_reg_r;
  crtt_pkg::crtt_vse_t             vert_sync_end_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     vert_display_end_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     vert_blank_start_reg_r;
  logic [crtt_pkg::BYTE_W-1:0]     vert_blank_end_reg_r;
  crtt_pkg::crtt_ext_t             ext_reg_r;
  crtt_pkg::crtt_misc_t            misc_reg_r;
  crtt_pkg::crtt_vpctrl_t          vpctrl_reg_r;
  logic                            irq_pin_enable_r;
  logic [crtt_pkg::CHAR_DIV_W-1:0] pix_cnt_r;
  logic                            char_tick;
  crtt_pkg::crtt_axis_cfg_t        h_cfg;
  crtt_pkg::crtt_axis_cfg_t        v_cfg;
  logic [crtt_pkg::HCNT_W-1:0]     h_count;
  logic [crtt_pkg::VCNT_W-1:0]     v_count;
  logic                            h_active;
  logic                            h_blank;
  logic                            h_sync;
  logic                            h_wrap;
  logic                            v_active;
  logic                            v_blank;
  logic                            v_sync;
  logic                            v_sync_hit;
  logic                            apb_wr;
  logic                            apb_acc;
  logic                            frame_clr;
  logic                            frame_irq_pending;
  logic                            vport_irq_pending;
  logic                            vref_d_r;
  logic                            vref_fall;
  logic                            strap_r;
  logic                            strap_ld_r;
  logic                            irq_req;
  logic [crtt_pkg::DATA_W-1:0]     rd_data;
  logic                            rd_ok;
  crtt_pkg::crtt_gfxext_t          gfx_rd;

  // ****************************************************************
  // Character clock
  // ****************************************************************
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
      pix_cnt_r <= '0;
    else
      pix_cnt_r <= crtt_pkg::CHAR_DIV_W'(pix_cnt_r + 1'b1);
  end

  assign char_tick = (pix_cnt_r == crtt_pkg::CHAR_LAST);

  // ****************************************************************
  // Event values
  // ****************************************************************
  always_comb
  begin
    h_cfg = '0;
    v_cfg = '0;
    // Extension bits complete the wide values
    h_cfg.total       = {1'b0, ext_reg_r.htotal_hi, horiz_total_reg_r};
    h_cfg.disp_end    = {1'b0, ext_reg_r.hdisp_hi,
                         horiz_display_end_reg_r};
    h_cfg.blank_start = {1'b0, ext_reg_r.hbs_hi, horiz_blank_start_reg_r};
    h_cfg.blank_end   = {2'b00, horiz_blank_end_reg_r};
    h_cfg.sync_start  = {1'b0, ext_reg_r.hss_hi, horiz_sync_start_reg_r};
    h_cfg.sync_end    = {2'b00, horiz_sync_end_reg_r};
    v_cfg.total       = {ext_reg_r.vtotal_hi, vert_total_reg_r};
    v_cfg.disp_end    = {ext_reg_r.vdisp_hi, vert_display_end_reg_r};
    v_cfg.blank_start = {ext_reg_r.vbs_hi, vert_blank_start_reg_r};
    v_cfg.blank_end   = {2'b00, vert_blank_end_reg_r};
    v_cfg.sync_start  = {ext_reg_r.vss_hi, vert_sync_start_reg_r};
    v_cfg.sync_end    = {6'h00, vert_sync_end_reg_r.sync_end};
  end

  // ****************************************************************
  // Raster counters
  // ****************************************************************
  // Horizontal axis counts characters from left-most pixel
  crtt_axis
  #(
    .W   (crtt_pkg::HCNT_W),
    .SEW (crtt_pkg::HSE_CMP_W),
    .BEW (crtt_pkg::HBE_CMP_W)
  )
  u_h_axis
  (
    .clk_i      (MCLK_I),
    .rst_n_i    (RESETN_I),
    .adv_i      (char_tick),
    .cfg_i      (h_cfg),
    .count_o    (h_count),
    .active_o   (h_active),
    .blank_o    (h_blank),
    .sync_o     (h_sync),
    .wrap_o     (h_wrap),
    .sync_hit_o ()
  );

  // Vertical axis counts scanlines from the top line
  crtt_axis
  #(
    .W   (crtt_pkg::VCNT_W),
    .SEW (crtt_pkg::VSE_CMP_W),
    .BEW (crtt_pkg::VBE_CMP_W)
  )
  u_v_axis
  (
    .clk_i      (MCLK_I),
    .rst_n_i    (RESETN_I),
    .adv_i      (h_wrap),
    .cfg_i      (v_cfg),
    .count_o    (v_count),
    .active_o   (v_active),
    .blank_o    (v_blank),
    .sync_o     (v_sync),
    .wrap_o     (),
    .sync_hit_o (v_sync_hit)
  );

  // ****************************************************************
  // Monitor outputs
  // ****************************************************************
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      HSYNC_O   <= 1'b0;
      VSYNC_O   <= 1'b0;
      BLANK_O   <= 1'b0;
      DISP_EN_O <= 1'b0;
    end
    else
    begin
      HSYNC_O   <= h_sync ^ misc_reg_r.hsync_neg;
      VSYNC_O   <= v_sync ^ misc_reg_r.vsync_neg;
      BLANK_O   <= h_blank | v_blank;
      DISP_EN_O <= h_active & v_active;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign apb_acc = PSEL_I && PENABLE_I;
  assign apb_wr  = apb_acc && PREADY_O && PWRITE_I;

  always_comb
  begin
    gfx_rd                   = '0;
    gfx_rd.vport_irq_pending = vport_irq_pending;
    gfx_rd.irq_pin_enable    = irq_pin_enable_r;
    rd_ok                    = 1'b1;
    rd_data                  = '0;
    unique case (PADDR_I)
      crtt_pkg::OFS_HTOTAL:  rd_data[7:0] = horiz_total_reg_r;
      crtt_pkg::OFS_HDISP:   rd_data[7:0] = horiz_display_end_reg_r;
      crtt_pkg::OFS_HBSTART: rd_data[7:0] = horiz_blank_start_reg_r;
      crtt_pkg::OFS_HBEND:   rd_data[7:0] = horiz_blank_end_reg_r;
      crtt_pkg::OFS_HSSTART: rd_data[7:0] = horiz_sync_start_reg_r;
      crtt_pkg::OFS_HSEND:   rd_data[7:0] = horiz_sync_end_reg_r;
      crtt_pkg::OFS_VTOTAL:  rd_data[7:0] = vert_total_reg_r;
      crtt_pkg::OFS_VSSTART: rd_data[7:0] = vert_sync_start_reg_r;
      crtt_pkg::OFS_VSEND:   rd_data[7:0] = vert_sync_end_reg_r;
      crtt_pkg::OFS_VDISP:   rd_data[7:0] = vert_display_end_reg_r;
      crtt_pkg::OFS_VBSTART: rd_data[7:0] = vert_blank_start_reg_r;
      crtt_pkg::OFS_VBEND:   rd_data[7:0] = vert_blank_end_reg_r;
      crtt_pkg::OFS_EXT:     rd_data[11:0] = ext_reg_r;
      crtt_pkg::OFS_MISC:    rd_data[7:0] = misc_reg_r;
      crtt_pkg::OFS_VPCTRL:  rd_data[7:0] = vpctrl_reg_r;
      crtt_pkg::OFS_FEAT:    rd_data[7] = frame_irq_pending;
      crtt_pkg::OFS_GFXEXT:  rd_data[7:0] = gfx_rd;
      // Line claimed only when the strap allows it
      crtt_pkg::OFS_CFGIRQ:  rd_data[7:0] = strap_r ? crtt_pkg::IRQ_NONE
                                                    : IRQ_PIN_CODE;
      crtt_pkg::OFS_POS:     rd_data[25:0] = {v_count, 7'h00, h_count};
      default:               rd_ok = 1'b0;
    endcase
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
    end
    else
    begin
      PREADY_O  <= apb_acc && !PREADY_O;
      PSLVERR_O <= apb_acc && !PREADY_O && !rd_ok;
      PRDATA_O  <= (apb_acc && !PREADY_O && !PWRITE_I && rd_ok)
                   ? rd_data : '0;
    end
  end

  // ****************************************************************
  // Timing registers
  // ****************************************************************
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      horiz_total_reg_r       <= crtt_pkg::RST_HTOTAL;
      horiz_display_end_reg_r <= crtt_pkg::RST_HDISP;
      horiz_blank_start_reg_r <= crtt_pkg::RST_HBSTART;
      horiz_blank_end_reg_r   <= crtt_pkg::RST_HBEND;
      horiz_sync_start_reg_r  <= crtt_pkg::RST_HSSTART;
      horiz_sync_end_reg_r    <= crtt_pkg::RST_HSEND;
      vert_total_reg_r        <= crtt_pkg::RST_VTOTAL;
      vert_sync_start_reg_r   <= crtt_pkg::RST_VSSTART;
      vert_display_end_reg_r  <= crtt_pkg::RST_VDISP;
      vert_blank_start_reg_r  <= crtt_pkg::RST_VBSTART;
      vert_blank_end_reg_r    <= crtt_pkg::RST_VBEND;
      ext_reg_r               <= crtt_pkg::RST_EXT;
      misc_reg_r              <= '0;
    end
    else if (apb_wr)
    begin
      unique case (PADDR_I)
        crtt_pkg::OFS_HTOTAL:  horiz_total_reg_r       <= PWDATA_I[7:0];
        crtt_pkg::OFS_HDISP:   horiz_display_end_reg_r <= PWDATA_I[7:0];
        crtt_pkg::OFS_HBSTART: horiz_blank_start_reg_r <= PWDATA_I[7:0];
        crtt_pkg::OFS_HBEND:   horiz_blank_end_reg_r   <= PWDATA_I[7:0];
        crtt_pkg::OFS_HSSTART: horiz_sync_start_reg_r  <= PWDATA_I[7:0];
        crtt_pkg::OFS_HSEND:   horiz_sync_end_reg_r    <= PWDATA_I[7:0];
        crtt_pkg::OFS_VTOTAL:  vert_total_reg_r        <= PWDATA_I[7:0];
        crtt_pkg::OFS_VSSTART: vert_sync_start_reg_r   <= PWDATA_I[7:0];
        crtt_pkg::OFS_VDISP:   vert_display_end_reg_r  <= PWDATA_I[7:0];
        crtt_pkg::OFS_VBSTART: vert_blank_start_reg_r  <= PWDATA_I[7:0];
        crtt_pkg::OFS_VBEND:   vert_blank_end_reg_r    <= PWDATA_I[7:0];
        crtt_pkg::OFS_EXT:     ext_reg_r  <= PWDATA_I[11:0];
        crtt_pkg::OFS_MISC:    misc_reg_r <= {PWDATA_I[7:6], 6'h00};
        default:               ;
      endcase
    end
  end

  // ****************************************************************
  // Interrupt control registers
  // ****************************************************************
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      vert_sync_end_reg_r <= {4'h0, crtt_pkg::RST_VSEND};
      vpctrl_reg_r        <= '0;
      irq_pin_enable_r    <= 1'b0;
    end
    else if (apb_wr)
    begin
      unique case (PADDR_I)
        // Clear bit is a strobe and never stored
        crtt_pkg::OFS_VSEND:   vert_sync_end_reg_r <=
                                 {3'h0, PWDATA_I[4:0]};
        crtt_pkg::OFS_VPCTRL:  vpctrl_reg_r <=
                                 {2'h0, PWDATA_I[5], 3'h0, PWDATA_I[1], 1'b0};
        crtt_pkg::OFS_GFXEXT:  irq_pin_enable_r <= PWDATA_I[2];
        default:               ;
      endcase
    end
  end

  assign frame_clr = apb_wr && (PADDR_I == crtt_pkg::OFS_VSEND)
                     && PWDATA_I[5];

  // ****************************************************************
  // Interrupt sources
  // ****************************************************************
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
      vref_d_r <= 1'b0;
    else
      vref_d_r <= VPORT_REF_I;
  end

  assign vref_fall = vref_d_r && !VPORT_REF_I;

  // Frame pending sets on entering vertical sync start
  crtt_flag u_frame_flag
  (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .set_i   (v_sync_hit),
    .clr_i   (frame_clr),
    .flag_o  (frame_irq_pending)
  );

  // Port pending held clear while its enable is low
  crtt_flag u_vport_flag
  (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .set_i   (vref_fall && vpctrl_reg_r.vport_irq_enable_clear),
    .clr_i   (!vpctrl_reg_r.vport_irq_enable_clear),
    .flag_o  (vport_irq_pending)
  );

  // Source select and per-source enables
  assign irq_req = vpctrl_reg_r.irq_source_select
                   ? vport_irq_pending
                   : (frame_irq_pending &&
                      vert_sync_end_reg_r.frame_irq_enable);

  // ****************************************************************
  // Strap capture and interrupt pin
  // ****************************************************************
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      strap_r    <= 1'b1;
      strap_ld_r <= 1'b0;
    end
    else if (!strap_ld_r)
    begin
      strap_r    <= IRQ_DISABLE_STRAP_I;
      strap_ld_r <= 1'b1;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
      IRQ_OUT_N_O <= 1'b1;
    else
      IRQ_OUT_N_O <= !(!strap_r && irq_pin_enable_r && irq_req);
  end

endmodule

// file: testbench/crtt_assertions.sv
// Port checks for the CRT raster timer
module crtt_assertions
(
  // Watched ports
  input wire logic        MCLK_I,
  input wire logic        RESETN_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        IRQ_DISABLE_STRAP_I,
  input wire logic        HSYNC_O,
  input wire logic        BLANK_O,
  input wire logic        DISP_EN_O,
  input wire logic        IRQ_OUT_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       done;
  logic [1:0] wr_q;
  logic [2:0] cfg_sr;
  assign done = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  always_ff @(posedge MCLK_I)
  begin
    // Frame clear reaches the pin two clocks after its write
    wr_q <= {wr_q[0], done};
  end
  // Raster checks start a few clocks after the extension write
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
      cfg_sr <= 3'h0;
    else
      cfg_sr <= {cfg_sr[1:0], cfg_sr[0] | (done && PADDR_I == 8'h30)};
  end
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);
  ready_wait_a: assert property ($rose(PENABLE_I) && PSEL_I |=> PREADY_O)
    else $error("no ready after access");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data outside answer");
  strap_quiet_a: assert property (
    IRQ_DISABLE_STRAP_I |-> IRQ_OUT_N_O)
    else $error("interrupt driven while strapped off");
  disp_noblank_a: assert property (
    cfg_sr[2] && DISP_EN_O |-> !BLANK_O && !HSYNC_O)
    else $error("active video overlaps blank or sync");
  hsync_width_a: assert property (
    $rose(HSYNC_O) && cfg_sr[2] |-> HSYNC_O[*8] ##1 !HSYNC_O)
    else $error("sync width not one character");
  irq_sticky_a: assert property (
    !IRQ_OUT_N_O && wr_q == 2'h0 && !done |=> !IRQ_OUT_N_O)
    else $error("interrupt dropped without a write");
endmodule

// file: testbench/crtt_monitor.sv
// Monitor model that times line, frame and active periods
module crtt_monitor
(
  // Timing from the raster block
  input  wire logic clk_i,
  input  wire logic hsync_i,
  input  wire logic vsync_i,
  input  wire logic disp_en_i,
  // Measured lengths in pixel clocks
  output logic [15:0] line_o,
  output logic [15:0] frame_o,
  output logic [15:0] active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        h_q;
  logic        v_q;
  logic [15:0] hc;
  logic [15:0] vc;
  logic [15:0] ac;
  // Leading sync edges delimit each line and frame
  always_ff @(posedge clk_i)
  begin
    h_q <= hsync_i;
    v_q <= vsync_i;
    hc  <= (hsync_i && !h_q) ? 16'h1 : hc + 16'h1;
    vc  <= (vsync_i && !v_q) ? 16'h1 : vc + 16'h1;
    ac  <= (vsync_i && !v_q) ? 16'(disp_en_i) : ac + 16'(disp_en_i);
    if (hsync_i && !h_q)
      line_o <= hc;
    if (vsync_i && !v_q)
      frame_o <= vc;
    if (vsync_i && !v_q)
      active_o <= ac;
  end
endmodule

// file: testbench/test_crt_raster_timing_and_frame_irq.sv
// Self-checking bench for the CRT raster timer
module test_crt_raster_timing_and_frame_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, pen, pwr, pready, perr, strap, vref;
  logic        hs, vs, blank, disp, irq_n, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] line_len, frame_len, act_len;
  int          n_fail = 0;
  int          total_checks = 0;
  crtt_top dut_u
  (
    .MCLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
    .IRQ_DISABLE_STRAP_I(strap), .VPORT_REF_I(vref), .HSYNC_O(hs),
    .VSYNC_O(vs), .BLANK_O(blank), .DISP_EN_O(disp), .IRQ_OUT_N_O(irq_n)
  );
  crtt_monitor mon_u
  (
    .clk_i(clk), .hsync_i(hs), .vsync_i(vs), .disp_en_i(disp),
    .line_o(line_len), .frame_o(frame_len), .active_o(act_len)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h2AA);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h44, 32'h0);
    chk(rd, 32'(crtt_pkg::IRQ_PIN_DEF));
    apb(1'b1, 8'h4C, 32'h5A);
    chk(er, 1'b1);
    $display("registers done");
  endtask
  task automatic t_raster();
    logic [7:0] ra [13] = '{8'h00, 8'h18, 8'h14, 8'h10, 8'h04, 8'h08,
                           8'h0C, 8'h24, 8'h28, 8'h2C, 8'h20, 8'h1C, 8'h30};
    logic [7:0] rv [13] = '{8'h09, 8'h05, 8'h08, 8'h07, 8'h06, 8'h06,
                           8'h09, 8'h03, 8'h03, 8'h05, 8'h05, 8'h04, 8'h00};
    for (int i = 0; i < 13; i++)
      apb(1'b1, ra[i], {24'h0, rv[i]});
    repeat (1300) @(posedge clk);
    chk(line_len, 16'd80);
    chk(frame_len, 16'd480);
    chk(act_len, 16'd144);
    $display("raster done");
  endtask
  task automatic t_frame();
    apb(1'b1, 8'h40, 32'h04);
    apb(1'b1, 8'h20, 32'h15);
    @(posedge vs);
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd[7], 1'b1);
    chk(irq_n, 1'b0);
    apb(1'b1, 8'h20, 32'h35);
    repeat (2) @(posedge clk);
    chk(irq_n, 1'b1);
    apb(1'b1, 8'h20, 32'h05);
    repeat (500) @(posedge clk);
    chk(irq_n, 1'b1);
    $display("frame interrupt done");
  endtask
  task automatic t_vport(input logic exp_n);
    apb(1'b1, 8'h40, 32'h04);
    apb(1'b1, 8'h38, 32'h22);
    @(posedge clk);
    vref <= 1'b1;
    @(posedge clk);
    vref <= 1'b0;
    repeat (4) @(posedge clk);
    chk(irq_n, exp_n);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd[4], 1'b1);
    apb(1'b1, 8'h38, 32'h20);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd[4], 1'b0);
    chk(irq_n, 1'b1);
    $display("port interrupt done");
  endtask
  task automatic t_pol();
    apb(1'b1, 8'h34, 32'h80);
    @(posedge disp);
    @(posedge clk);
    chk(vs, 1'b1);
    @(posedge blank);
    @(posedge clk);
    chk(disp, 1'b0);
    $display("polarity done");
  endtask
  initial
  begin
    clk = 1'b0;
    // Pixel rate above the limit: doubled upstream
    forever #5 clk = ~clk;
  end
  initial
  begin
    #300000;
    n_fail++;
    give_verdict();
  end
  initial
  begin
    {rst_n, psel, pen, pwr, strap, vref} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_raster();
    t_frame();
    t_vport(1'b0);
    t_pol();
    rst_n <= 1'b0;
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h0);
    t_vport(1'b1);
    give_verdict();
  end
endmodule
bind crtt_top crtt_assertions chk_u
(
  .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .IRQ_DISABLE_STRAP_I(IRQ_DISABLE_STRAP_I), .HSYNC_O(HSYNC_O),
  .BLANK_O(BLANK_O), .DISP_EN_O(DISP_EN_O), .IRQ_OUT_N_O(IRQ_OUT_N_O)
);
